// ==== pkg/cfh_pkg.sv ====
// Package with constants, states and carriers for the converter fault sequencer.
package cfh_pkg;

  localparam int unsigned CLK_MHZ = 25;
  // Cycle figures below are counted in switching cycles, marked by i_sense.cyc_start.
  localparam int unsigned OVL_LIMIT = 512;
  localparam int unsigned HICCUP_CYCLES = 16384;
  localparam int unsigned CNT_W = 15;
  localparam logic [CNT_W-1:0] CNT_ZERO = 15'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 15'h0001;

  typedef enum logic [2:0] {
    ST_DISCHARGE,
    ST_RUN,
    ST_OVL_HICCUP,
    ST_THERM_HOT,
    ST_THERM_HICCUP
  } cfh_state_t;

  typedef struct packed {
    logic cyc_start;
    logic peak_hit;
    logic ls_src_oc;
    logic ls_sink_oc;
    logic overload;
    logic over_temp;
  } cfh_sense_t;

  typedef struct packed {
    logic hs_on;
    logic ls_on;
  } cfh_gate_t;

endpackage : cfh_pkg

// ==== src/cfh_cycle_counter.sv ====
// Saturating cycle counter advanced on switching cycle starts.
`timescale 1ns/10ps
module cfh_cycle_counter (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_clear,
  input wire logic i_step,
  output logic [cfh_pkg::CNT_W-1:0] o_count
);

  typedef struct packed {
    logic [cfh_pkg::CNT_W-1:0] count;
  } cfh_cnt_state_t;

  cfh_cnt_state_t state_reg;
  cfh_cnt_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (i_clear) begin
      state_next.count = cfh_pkg::CNT_ZERO;
    end else if (i_step && (state_reg.count != {cfh_pkg::CNT_W{1'b1}})) begin
      state_next.count = state_reg.count + cfh_pkg::CNT_ONE;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_count = state_reg.count;

endmodule : cfh_cycle_counter

// ==== src/cfh_fault_sequencer.sv ====
// Cycle-by-cycle protection and hiccup sequencing for the switch gates.
// Operation
// - Peak current ends high-side on-time.
// - Low-side source limit skips next high-side.
// - High-side resumes only below source limit.
// - Sink limit turns both off till next.
// - Over 512 overload cycles shuts down.
// - Overload hiccup waits 16384 cycles, restarts.
// - Over-temperature stops switching immediately.
// - Temperature clearing starts thermal hiccup timer.
// - Thermal restart after 16384 counted cycles.
// - Restart waits for soft ramp discharged.
`timescale 1ns/10ps
module cfh_fault_sequencer (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire cfh_pkg::cfh_sense_t i_sense,
  input wire logic i_soft_ramp_pin_low,
  output cfh_pkg::cfh_gate_t o_gate,
  output logic o_soft_ramp_discharge,
  output logic o_switching,
  output logic o_shutdown
);

  typedef struct packed {
    cfh_pkg::cfh_state_t st;
    logic [9:0] ovl_cnt;
    logic skip_hs;
    logic hs_on;
    logic ls_on;
    logic sink_off;
  } cfh_seq_state_t;

  cfh_seq_state_t state_reg;
  cfh_seq_state_t state_next;
  logic [cfh_pkg::CNT_W-1:0] hic_count;
  logic hic_clear;
  logic hic_step;
  logic hic_done;

  // The shared hiccup counter runs only in the two waiting states.
  cfh_cycle_counter u_hiccup (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_clear(hic_clear),
    .i_step(hic_step),
    .o_count(hic_count)
  );

  assign hic_done = ({17'h00000, hic_count} >= cfh_pkg::HICCUP_CYCLES);

  always_comb begin
    state_next = state_reg;
    hic_clear = 1'b1;
    hic_step = 1'b0;
    case (state_reg.st)
      cfh_pkg::ST_DISCHARGE: begin
        state_next.hs_on = 1'b0;
        state_next.ls_on = 1'b0;
        state_next.ovl_cnt = 10'h000;
        state_next.skip_hs = 1'b0;
        if (i_sense.over_temp) begin
          // A hot die during the discharge wait still needs its hiccup.
          state_next.st = cfh_pkg::ST_THERM_HOT;
        end else if (i_soft_ramp_pin_low) begin
          state_next.st = cfh_pkg::ST_RUN;
        end
      end
      cfh_pkg::ST_RUN: begin
        if (i_sense.cyc_start) begin
          state_next.skip_hs = i_sense.ls_src_oc;
          state_next.sink_off = 1'b0;
          state_next.hs_on = !i_sense.ls_src_oc;
          state_next.ls_on = i_sense.ls_src_oc;
          if (i_sense.overload) begin
            state_next.ovl_cnt = state_reg.ovl_cnt + 10'h001;
          end else begin
            state_next.ovl_cnt = 10'h000;
          end
        end else begin
          if (state_reg.hs_on && i_sense.peak_hit) begin
            state_next.hs_on = 1'b0;
            state_next.ls_on = !state_reg.sink_off;
          end
          if (i_sense.ls_sink_oc && !state_reg.hs_on) begin
            state_next.ls_on = 1'b0;
            state_next.sink_off = 1'b1;
          end
        end
        if ({22'h000000, state_reg.ovl_cnt} > cfh_pkg::OVL_LIMIT) begin
          state_next.st = cfh_pkg::ST_OVL_HICCUP;
          state_next.hs_on = 1'b0;
          state_next.ls_on = 1'b0;
        end
        if (i_sense.over_temp) begin
          state_next.st = cfh_pkg::ST_THERM_HOT;
          state_next.hs_on = 1'b0;
          state_next.ls_on = 1'b0;
        end
      end
      cfh_pkg::ST_OVL_HICCUP: begin
        hic_clear = 1'b0;
        hic_step = i_sense.cyc_start;
        if (i_sense.over_temp) begin
          state_next.st = cfh_pkg::ST_THERM_HOT;
        end else if (hic_done) begin
          state_next.st = cfh_pkg::ST_DISCHARGE;
        end
      end
      cfh_pkg::ST_THERM_HOT: begin
        if (!i_sense.over_temp) begin
          state_next.st = cfh_pkg::ST_THERM_HICCUP;
        end
      end
      cfh_pkg::ST_THERM_HICCUP: begin
        hic_clear = 1'b0;
        hic_step = i_sense.cyc_start;
        if (i_sense.over_temp) begin
          state_next.st = cfh_pkg::ST_THERM_HOT;
        end else if (hic_done) begin
          state_next.st = cfh_pkg::ST_DISCHARGE;
        end
      end
      default: begin
        state_next.st = cfh_pkg::ST_DISCHARGE;
      end
    endcase
    if (i_sense.over_temp) begin
      state_next.hs_on = 1'b0;
      state_next.ls_on = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Gates are registered so a comparator glitch never reaches a switch.
  assign o_gate.hs_on = state_reg.hs_on;
  assign o_gate.ls_on = state_reg.ls_on;
  assign o_soft_ramp_discharge = (state_reg.st != cfh_pkg::ST_RUN);
  assign o_switching = (state_reg.st == cfh_pkg::ST_RUN);
  assign o_shutdown = (state_reg.st != cfh_pkg::ST_RUN) &&
                      (state_reg.st != cfh_pkg::ST_DISCHARGE);

endmodule : cfh_fault_sequencer

// ==== testbench/cfh_fault_sequencer_properties.sv ====
// Port assertions for the fault sequencer.
`timescale 1ns/10ps
module cfh_fault_sequencer_properties (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire cfh_pkg::cfh_sense_t i_sense,
  input wire logic i_soft_ramp_pin_low,
  input wire cfh_pkg::cfh_gate_t o_gate,
  input wire logic o_soft_ramp_discharge,
  input wire logic o_switching,
  input wire logic o_shutdown
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  wire cs = i_sense.cyc_start;
  wire run = o_switching && !i_sense.over_temp && !i_sense.overload;
  wire off = o_gate == 2'h0;
  peak_cut_a: assert property (
    run && o_gate.hs_on && i_sense.peak_hit && !cs |=> !o_gate.hs_on)
    else $error("peak");
  src_skip_a: assert property (
    run && cs && i_sense.ls_src_oc |=> o_gate == 2'h1) else $error("skip");
  src_ok_a: assert property (
    run && cs && !i_sense.ls_src_oc |=> o_gate == 2'h2) else $error("on");
  hs_rise_a: assert property (
    $rose(o_gate.hs_on) |-> $past(cs && !i_sense.ls_src_oc)) else $error("rise");
  sink_off_a: assert property (
    run && !o_gate.hs_on && i_sense.ls_sink_oc && !cs |=> off) else $error("sink");
  hold_off_a: assert property (
    off && !cs |=> off) else $error("hold");
  hot_stop_a: assert property (
    i_sense.over_temp |=> off && o_shutdown) else $error("hot");
  shut_idle_a: assert property (
    o_shutdown |-> off && !o_switching && o_soft_ramp_discharge)
    else $error("idle");
  ramp_wait_a: assert property (
    $rose(o_switching) |-> $past(i_soft_ramp_pin_low)) else $error("ramp");
  cover property ($rose(o_shutdown));
  cover property ($rose(o_switching));
  cover property (run && i_sense.ls_sink_oc);
endmodule : cfh_fault_sequencer_properties
bind cfh_fault_sequencer cfh_fault_sequencer_properties u_prop (.*);

// ==== testbench/cfh_power_stage.sv ====
// Behavioural power stage: cycle start pulses and peak current comparator.
`timescale 1ns/10ps
module cfh_power_stage (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_hs_on,
  input wire logic i_slow,
  output logic o_cyc_start,
  output logic o_peak_hit
);
  logic phase_reg;
  // Starts come two clocks apart, the tightest spacing allowed.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) phase_reg <= 1'h0;
    else phase_reg <= ~phase_reg;
  end
  assign o_cyc_start = phase_reg;
  // Current only climbs while the high side conducts; slow delays it.
  assign o_peak_hit = i_hs_on && !i_slow;
endmodule : cfh_power_stage

// ==== testbench/cfh_fault_sequencer_tb_top.sv ====
// Self-checking bench for the fault sequencer.
`timescale 1ns/10ps
module cfh_fault_sequencer_tb_top;
  logic clk = 1'h0, rst_b = 1'h0, ramp = 1'h0, slow = 1'h0;
  logic disch, sw, sd, cs, pk, s, c;
  logic [3:0] rnd = 4'h0;
  cfh_pkg::cfh_gate_t gate;
  int n_mismatch = 0, check_count = 0, n, r, cyc = 0;
  initial forever #20 clk = ~clk;
  cfh_power_stage u_ps (.i_clk(clk), .i_rst_b(rst_b), .i_hs_on(gate.hs_on),
    .i_slow(slow), .o_cyc_start(cs), .o_peak_hit(pk));
  cfh_fault_sequencer DUT (.i_clk(clk), .i_rst_b(rst_b),
    .i_sense(cfh_pkg::cfh_sense_t'({cs, pk, rnd})),
    .i_soft_ramp_pin_low(ramp), .o_gate(gate),
    .o_soft_ramp_discharge(disch), .o_switching(sw), .o_shutdown(sd));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  // Counts sampled cycle starts until the shutdown flag reaches w.
  task automatic count_to(input logic w, output int k);
    k = 0;
    // A call made at a falling edge counts the start seen there as well.
    if (clk) @(negedge clk);
    while (sd !== w) begin
      if (cs) k++;
      @(negedge clk);
    end
  endtask : count_to
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    void'($urandom(32'h2BCECD33));
    repeat (2) @(posedge clk);
    chk({11'h0, gate, disch, sw, sd}, 16'h0004);
    rst_b <= 1'h1;
    repeat (4) @(posedge clk);
    #1 chk({15'h0, sw}, 16'h0000);
    @(posedge clk) ramp <= 1'h1;
    repeat (2) @(posedge clk);
    #1 chk({15'h0, sw}, 16'h0001);
    repeat (400) begin
      @(negedge clk);
      s = rnd[3];
      c = cs;
      @(posedge clk);
      r = $urandom;
      rnd <= {r[0], r[1] & c, 2'h0};
      slow <= r[2];
      #1 if (c) chk({14'h0, gate}, {14'h0, ~s, s});
    end
    // A short overload, then one clean start, must not trip the hiccup.
    @(posedge clk) rnd <= 4'h2;
    repeat (600) @(posedge clk);
    rnd <= 4'h0;
    repeat (2) @(posedge clk);
    rnd <= 4'h2;
    count_to(1'h1, n);
    chk(16'(n), 16'(cfh_pkg::OVL_LIMIT + 1));
    count_to(1'h0, n);
    rnd <= 4'h0;
    chk(16'(n), 16'(cfh_pkg::HICCUP_CYCLES));
    repeat (4) @(posedge clk);
    #1 chk({15'h0, sw}, 16'h0001);
    @(posedge clk) rnd <= 4'h1;
    @(posedge clk);
    #1 chk({13'h0, gate, sd}, 16'h0001);
    repeat (50) @(negedge clk);
    @(negedge clk iff cs);
    @(posedge clk) rnd <= 4'h0;
    count_to(1'h0, n);
    chk(16'(n), 16'(cfh_pkg::HICCUP_CYCLES));
    repeat (4) @(posedge clk);
    #1 chk({15'h0, sw}, 16'h0001);
    test_done();
  end
endmodule : cfh_fault_sequencer_tb_top
